/* File: design/tpc_timer.sv */
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
// What this block does
// - PWM period equals reload times prescale in system clocks.
// - Non-0001H start count gives a one-shot first PWM period.
// - Polarity clear: output high for (reload minus PWM) of reload.
// - Polarity set: output high for PWM value of reload.
// - Capture copies the count into the PWM value register.
// - Capture counts prescaled clock ticks; polarity selects rising or falling edge.
// - Capture mode: a capture event interrupts without stopping or reloading the counter.
// - Capture mode: reaching reload interrupts and counting continues.
// - That first starting edge raises no interrupt.
// - Later edges capture, interrupt, restart count at 0001H.
// - Reaching compare value without capture interrupts, restarts at 0001H.
// - Elapsed time is (capture minus start) times prescale clocks.
// - Reading the count never disturbs counting.
module tpc_timer #(
    parameter int PRE_W = 3
) (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [15:0] reg_rdata,
    input  wire logic        timer_in,
    output logic             timer_out,
    output logic             irq
);
    tpc_pkg::tpc_ctrl_s ctrl;
    logic [15:0]        count;
    logic [15:0]        reload;
    logic [15:0]        pwm_value;
    logic [2:0]         status;
    logic [2:0]         mask;
    logic               started;
    logic               pwm_active;
    logic               tick;
    logic               edge_seen;
    tpc_pkg::tpc_event_s ev;
    logic [2:0]         ev_bits;
    logic [15:0]        next_count;
    logic               next_capture;
    logic               run;
    logic [15:0]        capture_value;
    logic [2:0]         next_status;
    logic               pwm_mode;
    logic               capture_mode;
    logic               capcmp_mode;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
        return a == o;
    endfunction

    function automatic logic [2:0] next_status_irq(input logic [2:0] s, input logic w,
                                                    input logic [2:0] c, input logic [2:0] e);
        return (s & ~(w ? c : 3'h0)) | e;
    endfunction

    // Shared mode decode: a mode only counts as running while enabled
    function automatic logic mode_on(input tpc_pkg::tpc_ctrl_s c,
                                     input tpc_pkg::tpc_mode_e m);
        return c.enable && (c.mode == m);
    endfunction

    wire wr_ctrl   = reg_write && hit(reg_addr, tpc_pkg::ADDR_CTRL);
    wire wr_count  = reg_write && hit(reg_addr, tpc_pkg::ADDR_COUNT);
    wire wr_reload = reg_write && hit(reg_addr, tpc_pkg::ADDR_RELOAD);
    wire wr_pwm    = reg_write && hit(reg_addr, tpc_pkg::ADDR_PWM);
    wire wr_status = reg_write && hit(reg_addr, tpc_pkg::ADDR_STATUS);
    wire wr_mask   = reg_write && hit(reg_addr, tpc_pkg::ADDR_MASK);

    assign pwm_mode     = mode_on(ctrl, tpc_pkg::TPC_MODE_PWM);
    assign capture_mode = mode_on(ctrl, tpc_pkg::TPC_MODE_CAPTURE);
    assign capcmp_mode  = mode_on(ctrl, tpc_pkg::TPC_MODE_CAPCMP);

    // capture/compare counter held until its first edge; that edge
    // already starts the prescaler, so no clock of elapsed time is lost
    assign run = pwm_mode || capture_mode || (capcmp_mode && (started || edge_seen));

    tpc_prescaler #(.SEL_W(PRE_W)) u_pre (
        .clock  (clock),
        .resetn (resetn),
        .run    (run),
        .sel    (ctrl.prescale),
        .tick   (tick)
    );

    tpc_edge_detect u_edge (
        .clock     (clock),
        .resetn    (resetn),
        .timer_in  (timer_in),
        .falling   (ctrl.timer_polarity_select),
        .edge_seen (edge_seen)
    );

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ctrl <= '{prescale: '0, mode: tpc_pkg::TPC_MODE_PWM,
                      timer_polarity_select: 1'b0, enable: 1'b0};
        end else if (wr_ctrl) begin
            ctrl.enable                <= reg_wdata[tpc_pkg::CTRL_EN_BIT];
            ctrl.timer_polarity_select <= reg_wdata[tpc_pkg::CTRL_POL_BIT];
            // mode and prescale locked while enabled
            if (!ctrl.enable) begin
                ctrl.mode     <= tpc_pkg::tpc_mode_e'(reg_wdata[tpc_pkg::CTRL_MODE_LSB +: 2]);
                ctrl.prescale <= reg_wdata[tpc_pkg::CTRL_PRE_LSB +: PRE_W];
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reload <= tpc_pkg::RELOAD_RST;
        end else if (wr_reload) begin
            reload <= reg_wdata;
        end
    end

    // Event decode and next count
    always_comb begin
        ev         = '0;
        next_count = count;
        next_capture = 1'b0;
        if (ctrl.enable) begin
            unique case (ctrl.mode)
                tpc_pkg::TPC_MODE_PWM: begin
                    if (tick) begin
                        // wrap at reload back to 0001H
                        if (count >= reload) begin
                            next_count = tpc_pkg::COUNT_START;
                            ev.reload  = 1'b1;
                        end else begin
                            next_count = 16'(count + 16'h0001);
                        end
                    end
                end
                tpc_pkg::TPC_MODE_CAPTURE: begin
                    if (edge_seen) begin
                        next_capture = 1'b1;
                        ev.capture   = 1'b1;
                    end
                    if (tick) begin
                        // reload match interrupts, count goes on
                        if (count == reload) begin
                            ev.reload = 1'b1;
                        end
                        next_count = 16'(count + 16'h0001);
                    end
                end
                tpc_pkg::TPC_MODE_CAPCMP: begin
                    if (started && edge_seen) begin
                        next_capture = 1'b1;
                        ev.capture   = 1'b1;
                        next_count   = tpc_pkg::COUNT_START;
                    end else if (started && tick) begin
                        if (count == reload) begin
                            ev.compare = 1'b1;
                            next_count = tpc_pkg::COUNT_START;
                        end else begin
                            next_count = 16'(count + 16'h0001);
                        end
                    end
                end
                default: begin
                    next_count = count;
                end
            endcase
        end
    end

    always_comb begin
        ev_bits                      = '0;
        ev_bits[tpc_pkg::EV_CAPTURE] = ev.capture;
        ev_bits[tpc_pkg::EV_RELOAD]  = ev.reload;
        ev_bits[tpc_pkg::EV_COMPARE] = ev.compare;
    end

    // first edge only starts counting, no event
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            started <= 1'b0;
        end else if (!capcmp_mode) begin
            started <= 1'b0;
        end else if (edge_seen) begin
            started <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count <= tpc_pkg::COUNT_START;
        end else if (wr_count) begin
            count <= reg_wdata;
        end else begin
            count <= next_count;
        end
    end

    // capture includes the step landing on this edge
    // so capture minus start equals the ticks between the two edges
    assign capture_value = tick ? 16'(count + 16'h0001) : count;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pwm_value <= tpc_pkg::ZERO16;
        end else if (next_capture) begin
            pwm_value <= capture_value;
        end else if (wr_pwm) begin
            pwm_value <= reg_wdata;
        end
    end

    // active from PWM match until reload
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pwm_active <= 1'b0;
        end else if (!pwm_mode) begin
            pwm_active <= 1'b0;
        end else if (ev.reload) begin
            pwm_active <= 1'b0;
        end else if (tick && count == pwm_value) begin
            pwm_active <= 1'b1;
        end
    end

    // polarity picks which phase drives high
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            timer_out <= 1'b0;
        end else if (pwm_mode) begin
            timer_out <= ctrl.timer_polarity_select ? ~pwm_active : pwm_active;
        end else begin
            timer_out <= ctrl.timer_polarity_select;
        end
    end

    // Set wins over a same-cycle write-one clear
    assign next_status = next_status_irq(status, wr_status,
                                         reg_wdata[tpc_pkg::EV_W-1:0], ev_bits);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            status <= '0;
        end else begin
            status <= next_status;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mask <= '0;
        end else if (wr_mask) begin
            mask <= reg_wdata[tpc_pkg::EV_W-1:0];
        end
    end

    // Built from the next status so the line rises on the edge that sets the flag
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_status & mask);
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= tpc_pkg::ZERO16;
        end else if (reg_read) begin
            unique case (reg_addr)
                tpc_pkg::ADDR_CTRL:   reg_rdata <= 16'({ctrl.prescale, 2'(ctrl.mode),
                                                       ctrl.timer_polarity_select, ctrl.enable});
                tpc_pkg::ADDR_COUNT:  reg_rdata <= count;
                tpc_pkg::ADDR_RELOAD: reg_rdata <= reload;
                tpc_pkg::ADDR_PWM:    reg_rdata <= pwm_value;
                tpc_pkg::ADDR_STATUS: reg_rdata <= 16'(status);
                tpc_pkg::ADDR_MASK:   reg_rdata <= 16'(mask);
                default:              reg_rdata <= tpc_pkg::ZERO16;
            endcase
        end else begin
            reg_rdata <= tpc_pkg::ZERO16;
        end
    end
endmodule // tpc_timer

/* File: design/tpc_pkg.sv */
package tpc_pkg;
    // Register offsets (16-bit register indices on the plain register port)
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_COUNT  = 4'h1;
    localparam logic [3:0] ADDR_RELOAD = 4'h2;
    localparam logic [3:0] ADDR_PWM    = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_MASK   = 4'h5;

    // Control register field positions
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_POL_BIT   = 1;
    localparam int CTRL_MODE_LSB  = 2;
    localparam int CTRL_PRE_LSB   = 4;

    // Status / mask bit positions
    localparam int EV_CAPTURE = 0;
    localparam int EV_RELOAD  = 1;
    localparam int EV_COMPARE = 2;
    localparam int EV_W       = 3;

    localparam logic [15:0] COUNT_START = 16'h0001;
    localparam logic [15:0] RELOAD_RST  = 16'hffff;
    localparam logic [15:0] ZERO16      = 16'h0000;

    typedef enum logic [1:0] {
        TPC_MODE_PWM,
        TPC_MODE_CAPTURE,
        TPC_MODE_CAPCMP,
        TPC_MODE_RSVD
    } tpc_mode_e;

    typedef struct packed {
        logic [2:0] prescale;
        tpc_mode_e  mode;
        logic       timer_polarity_select;
        logic       enable;
    } tpc_ctrl_s;

    typedef struct packed {
        logic capture;
        logic reload;
        logic compare;
    } tpc_event_s;
endpackage

/* File: design/tpc_prescaler.sv */
`timescale 1ns/1ps
// Divides the system clock by 2**sel; tick is a one-cycle pulse.
module tpc_prescaler #(
    parameter int SEL_W = 3
) (
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic             run,
    input  wire logic [SEL_W-1:0] sel,
    output logic                  tick
);
    localparam int DIV_W = (1 << SEL_W) - 1;

    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] limit;

    always_comb begin
        limit = DIV_W'((DIV_W'(1) << sel) - DIV_W'(1));
    end

    // Divider held cleared while stopped so each run starts phase-aligned
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            div  <= '0;
            tick <= 1'b0;
        end else if (!run) begin
            div  <= '0;
            tick <= 1'b0;
        end else if (div == limit) begin
            div  <= '0;
            tick <= 1'b1;
        end else begin
            div  <= DIV_W'(div + DIV_W'(1));
            tick <= 1'b0;
        end
    end
endmodule // tpc_prescaler

/* File: design/tpc_edge_detect.sv */
`timescale 1ns/1ps
// Flags the polarity-selected transition of the timer input.
module tpc_edge_detect (
    input  wire logic clock,
    input  wire logic resetn,
    input  wire logic timer_in,
    input  wire logic falling,
    output logic      edge_seen
);
    logic last_in;
    logic primed;

    // The first sample after reset only fills the history, so a pin
    // that idles high is not taken for a rising edge
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            last_in   <= 1'b0;
            primed    <= 1'b0;
            edge_seen <= 1'b0;
        end else begin
            last_in   <= timer_in;
            primed    <= 1'b1;
            edge_seen <= primed &&
                         (falling ? (last_in & ~timer_in) : (~last_in & timer_in));
        end
    end
endmodule // tpc_edge_detect

/* File: tb/tpc_asserts.sv */
`timescale 1ns/1ps
// Port-level checks; mirrors of the control, reload and mask registers stand in for the hidden state.
module tpc_asserts #(
    parameter int PRE_W = 3
) (
    input wire logic        clock,
    input wire logic        resetn,
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [15:0] reg_rdata,
    input wire logic        timer_in,
    input wire logic        timer_out,
    input wire logic        irq
);
    logic [PRE_W+3:0] ctrl_q;
    logic [15:0]      reload_q;
    logic [2:0]       mask_q;
    logic             pwm_on;

    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    assign pwm_on = ctrl_q[0] && (ctrl_q[3:2] == 2'h0);

    // Mode and prescale only move while the timer is stopped
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= '0;
        end else if (reg_write && reg_addr == tpc_pkg::ADDR_CTRL) begin
            ctrl_q[1:0] <= reg_wdata[1:0];
            if (!ctrl_q[0]) begin
                ctrl_q[PRE_W+3:2] <= reg_wdata[PRE_W+3:2];
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reload_q <= tpc_pkg::RELOAD_RST;
        end else if (reg_write && reg_addr == tpc_pkg::ADDR_RELOAD) begin
            reload_q <= reg_wdata;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mask_q <= 3'h0;
        end else if (reg_write && reg_addr == tpc_pkg::ADDR_MASK) begin
            mask_q <= reg_wdata[2:0];
        end
    end

    sequence cnt_rd_s;
        reg_read && reg_addr == tpc_pkg::ADDR_COUNT && !ctrl_q[0];
    endsequence
    sequence rest_s;
        !pwm_on && $stable(ctrl_q);
    endsequence

    rdata_idle_a: assert property (!reg_read |=> reg_rdata == 16'h0000)
        else $error("read data not zero outside a read");
    ctrl_read_a: assert property (reg_read && reg_addr == tpc_pkg::ADDR_CTRL
        |=> reg_rdata == 16'($past(ctrl_q))) else $error("control readback wrong");
    reload_read_a: assert property (reg_read && reg_addr == tpc_pkg::ADDR_RELOAD
        |=> reg_rdata == $past(reload_q)) else $error("reload readback wrong");
    mask_read_a: assert property (reg_read && reg_addr == tpc_pkg::ADDR_MASK
        |=> reg_rdata == {13'h0000, $past(mask_q)}) else $error("mask readback wrong");
    count_hold_a: assert property (cnt_rd_s ##1 cnt_rd_s |=> reg_rdata == $past(reg_rdata))
        else $error("count moved while stopped");
    out_rest_a: assert property (rest_s ##1 rest_s |-> timer_out == ctrl_q[1])
        else $error("output not at rest level");
    irq_masked_a: assert property (mask_q == 3'h0 && $past(mask_q) == 3'h0 |-> !irq)
        else $error("interrupt with all sources masked");
    irq_drop_a: assert property (reg_write && reg_addr == tpc_pkg::ADDR_MASK
        && reg_wdata[2:0] == 3'h0 |-> ##2 !irq) else $error("interrupt stayed after masking");
endmodule // tpc_asserts

/* File: tb/tpc_pin_model.sv */
`timescale 1ns/1ps
// Drives the timer input pin; edges land just after a rising clock edge.
module tpc_pin_model (
    input wire logic clock,
    output logic     timer_in
);
    initial timer_in = 1'b1;

    task automatic move(input logic level, input int gap);
        repeat (gap) @(posedge clock);
        timer_in <= level;
    endtask
endmodule // tpc_pin_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic        clock;
    logic        resetn;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_write;
    logic        reg_read;
    logic [15:0] reg_rdata;
    logic        timer_in;
    logic        timer_out;
    logic        irq;
    logic        rd_pend;
    logic [15:0] exp_q[$];
    logic [15:0] rv;
    int          errors;
    int          cmp_count;

    tpc_timer dut_u (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .timer_in(timer_in), .timer_out(timer_out), .irq(irq));
    tpc_pin_model pm_u (.clock(clock), .timer_in(timer_in));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Looks at irq mid-cycle, away from the edge that updates it
    task automatic chk_irq(input logic exp);
        @(negedge clock);
        chk("irq", {15'h0000, exp}, {15'h0000, irq});
        @(posedge clock);
    endtask

    // A strobe stays up across back-to-back transfers of its own kind; wr and rd lower the other strobe, wt lowers both
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        reg_read <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] d);
        exp_q.push_back(d);
        reg_addr <= a;
        reg_write <= 1'b0;
        reg_read <= 1'b1;
        @(posedge clock);
    endtask
    task automatic wt(input int n);
        reg_write <= 1'b0;
        reg_read <= 1'b0;
        repeat (n) @(posedge clock);
    endtask
    // Whole periods only, so the count does not depend on phase
    task automatic meas(input logic [15:0] exp);
        logic [15:0] hi;
        hi = 16'h0000;
        repeat (64) begin
            @(negedge clock);
            hi = hi + 16'(timer_out === 1'b1);
        end
        chk("timer_out high time", exp, hi);
        @(posedge clock);
    endtask

    always @(posedge clock) rd_pend <= reg_read && resetn;
    always @(negedge clock) begin
        if (rd_pend) begin
            chk("reg_rdata", exp_q.pop_front(), reg_rdata);
        end
    end

    task automatic final_report();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        #400000;
        errors++;
        final_report();
    end

    initial begin
        errors = 0;
        cmp_count = 0;
        rd_pend = 1'b0;
        resetn = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_write = 1'b0;
        reg_read = 1'b0;
        void'($urandom(53));
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        for (int i = 0; i < 7; i++) begin
            rd((i == 6) ? 4'hf : 4'(i), (i == 1) ? 16'h0001 : (i == 2) ? 16'hffff : 16'h0000);
        end
        rd(tpc_pkg::ADDR_COUNT, 16'h0001);
        rd(tpc_pkg::ADDR_COUNT, 16'h0001);
        repeat (4) begin
            rv = 16'($urandom);
            wr(tpc_pkg::ADDR_RELOAD, rv);
            rd(tpc_pkg::ADDR_RELOAD, rv);
        end
        wr(4'h6, rv);
        rd(4'h6, 16'h0000);
        // reload above compare, written in order, enabled last
        wr(tpc_pkg::ADDR_CTRL, 16'h0010);
        wr(tpc_pkg::ADDR_PWM, 16'h0003);
        wr(tpc_pkg::ADDR_RELOAD, 16'h0008);
        wr(tpc_pkg::ADDR_COUNT, 16'h0001);
        wr(tpc_pkg::ADDR_CTRL, 16'h0011);
        wt(40);
        meas(16'h0028);
        wr(tpc_pkg::ADDR_CTRL, 16'h0073);
        rd(tpc_pkg::ADDR_CTRL, 16'h0013);
        wt(32);
        meas(16'h0018);
        wr(tpc_pkg::ADDR_CTRL, 16'h0000);
        wr(tpc_pkg::ADDR_CTRL, 16'h000a);
        wr(tpc_pkg::ADDR_COUNT, 16'h0001);
        wr(tpc_pkg::ADDR_RELOAD, 16'h0064);
        wr(tpc_pkg::ADDR_STATUS, 16'h0007);
        wr(tpc_pkg::ADDR_MASK, 16'h0007);
        wr(tpc_pkg::ADDR_CTRL, 16'h000b);
        wt(5);
        rd(tpc_pkg::ADDR_COUNT, 16'h0001);
        pm_u.move(1'b0, 0);
        wt(10);
        chk_irq(1'b0);
        wt(9);
        pm_u.move(1'b1, 0);
        wt(20);
        pm_u.move(1'b0, 0);
        wt(6);
        chk_irq(1'b1);
        rd(tpc_pkg::ADDR_STATUS, 16'h0001);
        rd(tpc_pkg::ADDR_PWM, 16'h0029);
        wr(tpc_pkg::ADDR_STATUS, 16'h0001);
        wt(3);
        chk_irq(1'b0);
        wt(100);
        rd(tpc_pkg::ADDR_STATUS, 16'h0004);
        wr(tpc_pkg::ADDR_MASK, 16'h0000);
        wr(tpc_pkg::ADDR_STATUS, 16'h0007);
        wr(tpc_pkg::ADDR_CTRL, 16'h0000);
        wr(tpc_pkg::ADDR_CTRL, 16'h0004);
        wr(tpc_pkg::ADDR_COUNT, 16'h0001);
        wr(tpc_pkg::ADDR_RELOAD, 16'h001e);
        wr(tpc_pkg::ADDR_MASK, 16'h0007);
        wr(tpc_pkg::ADDR_CTRL, 16'h0005);
        wt(40);
        pm_u.move(1'b1, 0);
        wt(6);
        rd(tpc_pkg::ADDR_STATUS, 16'h0003);
        wt(3);
        final_report();
    end
endmodule // tb_top

bind tpc_timer tpc_asserts #(.PRE_W(PRE_W)) chk_u (.clock(clock), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .timer_in(timer_in), .timer_out(timer_out), .irq(irq));
